// file: hw/sqd_decoder.sv
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module sqd_decoder
   import sqd_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Avalon-MM slave.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int SPW = $clog2(DEPTH);

   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_READ, ST_EXEC} sqd_state_t;

   sqd_state_t state_reg;
   logic [LINE_W-1:0] line_reg;
   logic [PC_W-1:0] pc_reg;
   logic [7:0] acc_reg;
   logic [7:0] sindex_reg;
   logic carry_reg;
   logic zero_reg;
   logic run_reg;
   logic [PC_W-1:0] paddr_reg;
   logic [7:0] raddr_reg;
   logic [PC_W-1:0] stack_reg [DEPTH];
   logic [SPW:0] sp_reg;
   logic [LINE_W-1:0] prog_rdata;
   logic [7:0] reg_rdata;
   logic wr_go;
   logic halted;
   logic prog_we;
   logic reg_we;
   logic [7:0] reg_waddr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rsel;
   logic [3:0] ctl;
   logic ret_bit;
   logic [7:0] dst_sel;
   logic [PC_W-1:0] nxt_addr;
   logic [7:0] src_sel;
   logic [7:0] imm;
   logic is_f2;
   logic is_f3;
   logic [7:0] src_val;
   logic [7:0] operand;
   logic [7:0] alu_res;
   logic carry_next;
   logic carry_upd;
   logic taken;
   logic is_call;
   logic dst_discard;
   logic seq_we;
   logic [PC_W-1:0] pc_inc;
   logic [PC_W-1:0] stack_top;
   logic [8:0] sum9;
   logic [15:0] rot16;
   logic [8:0] sh9;

   // ==========================================================
   // Bus slave.
   assign wr_go = avs_write && !avs_waitrequest;
   assign halted = (state_reg == ST_IDLE) && !run_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= RD_UNMAPPED;
      end else if (avs_read && avs_waitrequest) begin
         case (avs_address)
            ADDR_CTRL: avs_readdata <= {31'h0000_0000, run_reg};
            ADDR_STATUS: avs_readdata <= {16'h0000, 4'(sp_reg), zero_reg, carry_reg, (state_reg != ST_IDLE), pc_reg};
            ADDR_ACCIDX: avs_readdata <= {16'h0000, sindex_reg, acc_reg};
            ADDR_PADDR: avs_readdata <= {23'h00_0000, paddr_reg};
            ADDR_RADDR: avs_readdata <= {24'h00_0000, raddr_reg};
            ADDR_RDATA: avs_readdata <= {24'h00_0000, reg_rdata};
            default: avs_readdata <= RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run_reg <= 1'b0;
      end else if (wr_go && avs_address == ADDR_CTRL) begin
         run_reg <= avs_writedata[CTRL_RUN];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         paddr_reg <= PC_RESET;
      end else if (wr_go && avs_address == ADDR_PADDR) begin
         paddr_reg <= avs_writedata[PC_W-1:0];
      end else if (prog_we) begin
         paddr_reg <= PC_W'(paddr_reg + 1'b1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         raddr_reg <= BYTE_RESET;
      end else if (wr_go && avs_address == ADDR_RADDR) begin
         raddr_reg <= avs_writedata[7:0];
      end
   end

   // ==========================================================
   // Program and register memories.
   assign prog_we = wr_go && (avs_address == ADDR_PDATA) && halted;

   sqd_mem #(.WIDTH(LINE_W), .AW(PC_W)) u_prog (
      .clk(clk),
      .nrst(nrst),
      .we(prog_we),
      .waddr(paddr_reg),
      .wdata(avs_writedata[LINE_W-1:0]),
      .raddr(pc_reg),
      .rdata(prog_rdata)
   );

   assign reg_rsel = halted ? raddr_reg : src_sel;
   assign reg_we = seq_we || (wr_go && (avs_address == ADDR_RDATA) && halted);
   assign reg_waddr = seq_we ? dst_sel : raddr_reg;
   assign reg_wdata = seq_we ? alu_res : avs_writedata[7:0];

   sqd_mem #(.WIDTH(8), .AW(8)) u_regs (
      .clk(clk),
      .nrst(nrst),
      .we(reg_we),
      .waddr(reg_waddr),
      .wdata(reg_wdata),
      .raddr(reg_rsel),
      .rdata(reg_rdata)
   );

   // ==========================================================
   // Line fields and format decode.
   assign ctl = line_reg[CTL_MSB:CTL_LSB];
   assign ret_bit = line_reg[RET_BIT];
   assign dst_sel = line_reg[DST_MSB:DST_LSB];
   assign nxt_addr = line_reg[NXT_MSB:NXT_LSB];
   assign src_sel = line_reg[SRC_MSB:SRC_LSB];
   assign imm = line_reg[IMM_MSB:IMM_LSB];
   assign is_f3 = ctl[3];
   assign is_f2 = (ctl == OP_ROL);
   assign is_call = is_f3 && (ctl == OP_CALL);
   assign pc_inc = PC_W'(pc_reg + 1'b1);
   assign stack_top = stack_reg[SPW'(sp_reg - 1'b1)];

   // ==========================================================
   // Source and operand selection.
   always_comb begin
      case (src_sel)
         SEL_ALLONES: src_val = VAL_ONES;
         SEL_ALLZEROS: src_val = VAL_ZEROS;
         SEL_ACC: src_val = acc_reg;
         SEL_SINDEX: src_val = sindex_reg;
         default: src_val = reg_rdata;
      endcase
   end

   always_comb begin
      operand = imm;
      if (!is_f3 || ctl == OP_JZ || ctl == OP_JNZ) begin
         if (imm == VAL_ZEROS) begin
            operand = acc_reg;
         end
      end
   end

   // ==========================================================
   // ALU.
   assign sum9 = 9'({1'b0, src_val} + {1'b0, operand} + {8'h00, (ctl == OP_ADC) && carry_reg});
   assign rot16 = {src_val, src_val};
   assign sh9 = (imm[4:3] == SH_SHL) ? 9'({1'b0, src_val} << imm[2:0]) : 9'({src_val, 1'b0} >> imm[2:0]);

   always_comb begin
      alu_res = src_val;
      carry_next = carry_reg;
      carry_upd = 1'b0;
      if (is_f3) begin
         alu_res = (ctl == OP_JZ || ctl == OP_JNZ) ? (src_val & operand) : (src_val | imm);
      end else begin
         case (ctl)
            OP_OR: alu_res = src_val | operand;
            OP_AND: alu_res = src_val & operand;
            OP_XOR: alu_res = src_val ^ operand;
            OP_ADD, OP_ADC: begin
               alu_res = sum9[7:0];
               carry_next = sum9[8];
               carry_upd = 1'b1;
            end
            OP_ROL: begin
               carry_upd = 1'b1;
               case (imm[4:3])
                  SH_ROL: alu_res = 8'(rot16 >> (4'h8 - {1'b0, imm[2:0]}));
                  SH_ROR: alu_res = 8'(rot16 >> imm[2:0]);
                  SH_SHL: alu_res = sh9[7:0];
                  default: alu_res = sh9[8:1];
               endcase
               case (imm[4:3])
                  SH_ROL: carry_next = (imm[2:0] == 3'h0) ? carry_reg : alu_res[0];
                  SH_ROR: carry_next = (imm[2:0] == 3'h0) ? carry_reg : alu_res[7];
                  SH_SHL: carry_next = sh9[8];
                  default: carry_next = sh9[0];
               endcase
            end
            default: alu_res = src_val;
         endcase
      end
   end

   always_comb begin
      case (ctl)
         OP_JMP, OP_CALL: taken = 1'b1;
         OP_JZ: taken = (alu_res == VAL_ZEROS);
         OP_JNZ: taken = (alu_res != VAL_ZEROS);
         OP_JC: taken = carry_reg;
         OP_JNC: taken = !carry_reg;
         default: taken = 1'b0;
      endcase
   end

   // ==========================================================
   // Destination write-back.
   assign dst_discard = (dst_sel == SEL_NONE) || (dst_sel == SEL_ALLONES);
   assign seq_we = (state_reg == ST_EXEC) && !is_f3 && !dst_discard && dst_sel != SEL_ACC
                   && dst_sel != SEL_SINDEX;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_reg <= BYTE_RESET;
      end else if (state_reg == ST_EXEC && !is_f3 && dst_sel == SEL_ACC) begin
         acc_reg <= alu_res;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sindex_reg <= BYTE_RESET;
      end else if (state_reg == ST_EXEC && (is_f3 || dst_sel == SEL_SINDEX)) begin
         sindex_reg <= alu_res;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zero_reg <= 1'b0;
         carry_reg <= 1'b0;
      end else if (state_reg == ST_EXEC) begin
         zero_reg <= (alu_res == VAL_ZEROS);
         if (carry_upd) begin
            carry_reg <= carry_next;
         end
      end
   end

   // ==========================================================
   // Sequencer state and line capture.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: state_reg <= run_reg ? ST_FETCH : ST_IDLE;
            ST_FETCH: state_reg <= ST_LOAD;
            ST_LOAD: state_reg <= ST_READ;
            ST_READ: state_reg <= ST_EXEC;
            ST_EXEC: state_reg <= run_reg ? ST_FETCH : ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         line_reg <= '0;
      end else if (state_reg == ST_LOAD) begin
         line_reg <= prog_rdata;
      end
   end

   // ==========================================================
   // Program counter and return stack.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_reg <= PC_RESET;
      end else if (halted && wr_go && avs_address == ADDR_CTRL && avs_writedata[CTRL_CLRPC]) begin
         pc_reg <= PC_RESET;
      end else if (state_reg == ST_EXEC) begin
         if (is_f3 && taken) begin
            pc_reg <= nxt_addr;
         end else if (!is_f3 && ret_bit && sp_reg != '0) begin
            pc_reg <= stack_top;
         end else begin
            pc_reg <= pc_inc;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sp_reg <= '0;
      end else if (halted && wr_go && avs_address == ADDR_CTRL && avs_writedata[CTRL_CLRPC]) begin
         sp_reg <= '0;
      end else if (state_reg == ST_EXEC) begin
         if (is_call && sp_reg != (SPW+1)'(DEPTH)) begin
            sp_reg <= (SPW+1)'(sp_reg + 1'b1);
         end else if (!is_f3 && ret_bit && sp_reg != '0) begin
            sp_reg <= (SPW+1)'(sp_reg - 1'b1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (state_reg == ST_EXEC && is_call && sp_reg != (SPW+1)'(DEPTH)) begin
         stack_reg[SPW'(sp_reg)] <= pc_inc;
      end
   end

   // ==========================================================
   // Assertions.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_line_capture: assert property (state_reg == ST_LOAD |=> line_reg == $past(prog_rdata))
      else $error("line register did not capture program data");
   a_acc_load: assert property (state_reg == ST_EXEC && !is_f3 && dst_sel == SEL_ACC
      |=> acc_reg == $past(alu_res))
      else $error("accumulator not loaded from alu");
   a_acc_hold: assert property (state_reg != ST_EXEC || is_f3 || dst_sel != SEL_ACC |=> $stable(acc_reg))
      else $error("accumulator changed without being destination");
   a_sindex_branch: assert property (state_reg == ST_EXEC && is_f3 |=> sindex_reg == $past(alu_res))
      else $error("branch result not in source index");
   a_branch_taken: assert property (state_reg == ST_EXEC && is_f3 && taken |=> pc_reg == $past(nxt_addr))
      else $error("taken branch did not load next address");
   a_seq_flow: assert property (state_reg == ST_EXEC && !(is_f3 && taken) && !(!is_f3 && ret_bit)
      |=> pc_reg == $past(pc_inc))
      else $error("sequential flow did not increment");
   a_call_push: assert property (state_reg == ST_EXEC && is_call && sp_reg == '0
      |=> sp_reg == 1 && stack_reg[0] == $past(pc_inc))
      else $error("call did not push return address");
   a_ret_pop: assert property (state_reg == ST_EXEC && !is_f3 && ret_bit && sp_reg != '0
      |=> pc_reg == $past(stack_top) && sp_reg == $past(sp_reg) - 1)
      else $error("return did not pop stack");
   a_none_discard: assert property (state_reg == ST_EXEC && !is_f3 && dst_discard |-> !reg_we)
      else $error("discard destination was written");
   a_const_ones: assert property (src_sel == SEL_ALLONES |-> src_val == VAL_ONES)
      else $error("all ones source wrong");
   a_const_zeros: assert property (src_sel == SEL_ALLZEROS |-> src_val == VAL_ZEROS)
      else $error("all zeros source wrong");
   a_acc_operand: assert property (!is_f3 && imm == VAL_ZEROS |-> operand == acc_reg)
      else $error("zero immediate did not select accumulator");
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");

   c_call: cover property (state_reg == ST_EXEC && is_call);
   c_ret: cover property (state_reg == ST_EXEC && !is_f3 && ret_bit && sp_reg != '0);
   c_jz_taken: cover property (state_reg == ST_EXEC && ctl == OP_JZ && taken);
   c_rotate: cover property (state_reg == ST_EXEC && is_f2);
endmodule : sqd_decoder

// file: hw/sqd_pkg.sv
package sqd_pkg;
   // ==========================================================
   // Command line layout.
   localparam int LINE_W = 29;
   localparam int CTL_MSB = 28;
   localparam int CTL_LSB = 25;
   localparam int RET_BIT = 24;
   localparam int DST_MSB = 23;
   localparam int DST_LSB = 16;
   localparam int NXT_MSB = 24;
   localparam int NXT_LSB = 16;
   localparam int SRC_MSB = 15;
   localparam int SRC_LSB = 8;
   localparam int IMM_MSB = 7;
   localparam int IMM_LSB = 0;
   localparam int PC_W = 9;
   localparam int STACK_DEPTH = 4;
   // ==========================================================
   // ALU and branch control encodings.
   localparam logic [3:0] OP_OR = 4'h0;
   localparam logic [3:0] OP_AND = 4'h1;
   localparam logic [3:0] OP_XOR = 4'h2;
   localparam logic [3:0] OP_ADD = 4'h3;
   localparam logic [3:0] OP_ADC = 4'h4;
   localparam logic [3:0] OP_ROL = 4'h5;
   localparam logic [3:0] OP_JMP = 4'h8;
   localparam logic [3:0] OP_JZ = 4'h9;
   localparam logic [3:0] OP_JNZ = 4'ha;
   localparam logic [3:0] OP_JC = 4'hb;
   localparam logic [3:0] OP_JNC = 4'hc;
   localparam logic [3:0] OP_CALL = 4'hd;
   // Shift control modes in bits 4..3, count in bits 2..0.
   localparam logic [1:0] SH_ROL = 2'h0;
   localparam logic [1:0] SH_ROR = 2'h1;
   localparam logic [1:0] SH_SHL = 2'h2;
   localparam logic [1:0] SH_SHR = 2'h3;
   // ==========================================================
   // Special register selections.
   localparam logic [7:0] SEL_ALLONES = 8'hff;
   localparam logic [7:0] SEL_ALLZEROS = 8'hfe;
   localparam logic [7:0] SEL_NONE = 8'hfe;
   localparam logic [7:0] SEL_ACC = 8'h61;
   localparam logic [7:0] SEL_SINDEX = 8'h65;
   localparam logic [7:0] VAL_ONES = 8'hff;
   localparam logic [7:0] VAL_ZEROS = 8'h00;
   // ==========================================================
   // Register map, byte addresses.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_ACCIDX = 8'h08;
   localparam logic [7:0] ADDR_PADDR = 8'h0c;
   localparam logic [7:0] ADDR_PDATA = 8'h10;
   localparam logic [7:0] ADDR_RADDR = 8'h14;
   localparam logic [7:0] ADDR_RDATA = 8'h18;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_CLRPC = 1;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   localparam logic [PC_W-1:0] PC_RESET = 9'h000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : sqd_pkg

// file: hw/sqd_mem.sv
`timescale 1ns/10ps
module sqd_mem #(
   parameter int WIDTH = 8,
   parameter int AW = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Write port.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Registered read port.
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [2**AW];

   // ==========================================================
   // Storage array.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // ==========================================================
   // Read data register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule : sqd_mem

// file: verification/sqd_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// Avalon-MM master standing in for host software.
module sqd_host_model (
   // Clock.
   input wire logic clk,
   // Master request side.
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   // Slave answer side.
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Count of waits that ran out.
   output int n_to
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      n_to = 0;
   end

   // One transfer; entered just after a rising edge, holds until waitrequest is sampled low at a rising edge or 50 further edges pass without it.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      i = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && i < 50) begin
         @(posedge clk);
         i++;
      end
      if (avs_waitrequest !== 1'b0) begin
         n_to++;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : xfer
endmodule : sqd_host_model

// file: verification/test_sequencer_command_line_decoder.sv
`timescale 1ns/10ps
module test_sequencer_command_line_decoder;
   import sqd_pkg::*;
   typedef struct {
      logic [28:0] l1;
      logic [28:0] l3;
      logic [7:0] acc;
      logic [7:0] sx;
      logic [7:0] r10;
      logic [8:0] pc;
      logic [3:0] dep;
   } sqd_row_t;
   logic clk;
   logic nrst;
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int n_to;
   int n_fail;
   int n_checks;
   sqd_row_t rows [18];
   logic [31:0] q;
   logic [28:0] l0;
   logic [28:0] jt;

   sqd_decoder sqd_decoder_i (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   sqd_host_model sqd_host_model_i (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .n_to(n_to));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================================
   // Line builders, compare and bus tasks.
   function automatic logic [28:0] f1(input logic [3:0] c, input logic r, input logic [7:0] d,
      input logic [7:0] s, input logic [7:0] i);
      return {c, r, d, s, i};
   endfunction : f1
   function automatic logic [28:0] f3(input logic [3:0] c, input logic [8:0] n, input logic [7:0] s,
      input logic [7:0] i);
      return {c, n, s, i};
   endfunction : f3
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic final_report;
      n_fail = n_fail + n_to;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      sqd_host_model_i.xfer(1'b1, a, d, x);
      if (n_to != 0) final_report();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      sqd_host_model_i.xfer(1'b0, a, 32'h0000_0000, d);
      if (n_to != 0) final_report();
   endtask : rd
   task automatic run_prog(input logic [28:0] a, input logic [28:0] b);
      wr(ADDR_PADDR, 32'h0000_0000);
      wr(ADDR_PDATA, {3'h0, l0});
      wr(ADDR_PDATA, {3'h0, a});
      wr(ADDR_PDATA, {3'h0, f3(OP_JMP, 9'h002, SEL_SINDEX, 8'h00)});
      wr(ADDR_PDATA, {3'h0, b});
      wr(ADDR_CTRL, 32'h0000_0002);
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (60) @(posedge clk);
      wr(ADDR_CTRL, 32'h0000_0000);
      repeat (8) @(posedge clk);
   endtask : run_prog

   // ==========================================================
   // Main sequence.
   initial begin
      nrst = 1'b0;
      n_fail = 0;
      n_checks = 0;
      l0 = f1(OP_OR, 1'b0, SEL_ACC, SEL_ALLZEROS, 8'h5a);
      jt = f3(OP_JMP, 9'h003, SEL_SINDEX, 8'h00);
      rows[0] = '{f1(OP_OR, 1'b0, 8'h10, SEL_ALLONES, 8'h00), jt, 8'h5a, 8'h00, 8'hff, 9'h002, 4'h0};
      rows[1] = '{f1(OP_AND, 1'b0, 8'h10, SEL_ALLONES, 8'h00), jt, 8'h5a, 8'h00, 8'h5a, 9'h002, 4'h0};
      rows[2] = '{f1(OP_ADD, 1'b0, 8'h10, SEL_ALLZEROS, 8'h11), jt, 8'h5a, 8'h00, 8'h11, 9'h002, 4'h0};
      rows[3] = '{f1(OP_ADD, 1'b0, SEL_ACC, SEL_ALLONES, 8'h01), jt, 8'h00, 8'h00, 8'h11, 9'h002, 4'h0};
      rows[4] = '{f1(OP_XOR, 1'b0, SEL_NONE, SEL_ALLONES, 8'h0f), jt, 8'h5a, 8'h00, 8'h11, 9'h002, 4'h0};
      rows[5] = '{f1(OP_OR, 1'b0, SEL_ACC, 8'h10, 8'h80), jt, 8'h91, 8'h00, 8'h11, 9'h002, 4'h0};
      rows[6] = '{f1(OP_ROL, 1'b0, 8'h10, SEL_ACC, 8'h01), jt, 8'h5a, 8'h00, 8'hb4, 9'h002, 4'h0};
      rows[7] = '{f1(OP_ROL, 1'b0, 8'h10, SEL_ACC, 8'h1c), jt, 8'h5a, 8'h00, 8'h05, 9'h002, 4'h0};
      rows[8] = '{f3(OP_JMP, 9'h003, SEL_ALLZEROS, 8'h33), jt, 8'h5a, 8'h33, 8'h05, 9'h003, 4'h0};
      rows[9] = '{f3(OP_JZ, 9'h003, SEL_ACC, 8'ha5), jt, 8'h5a, 8'h00, 8'h05, 9'h003, 4'h0};
      rows[10] = '{f3(OP_JNZ, 9'h003, SEL_ACC, 8'ha5), jt, 8'h5a, 8'h00, 8'h05, 9'h002, 4'h0};
      rows[11] = '{f3(OP_CALL, 9'h003, SEL_ALLZEROS, 8'h07), jt, 8'h5a, 8'h07, 8'h05, 9'h003, 4'h1};
      rows[12] = '{f3(OP_CALL, 9'h003, SEL_ALLZEROS, 8'h07), f1(OP_OR, 1'b1, SEL_NONE, SEL_ALLZEROS, 8'h01),
         8'h5a, 8'h07, 8'h05, 9'h002, 4'h0};
      rows[13] = '{f3(OP_JC, 9'h003, SEL_ALLZEROS, 8'h00), jt, 8'h5a, 8'h00, 8'h05, 9'h003, 4'h0};
      rows[14] = '{f3(OP_JNC, 9'h003, SEL_ALLZEROS, 8'h44), jt, 8'h5a, 8'h44, 8'h05, 9'h002, 4'h0};
      rows[15] = '{f1(OP_ADC, 1'b0, 8'h10, SEL_ALLONES, 8'h01), jt, 8'h5a, 8'h44, 8'h01, 9'h002, 4'h0};
      rows[16] = '{f1(OP_ROL, 1'b0, 8'h10, SEL_ACC, 8'h0b), jt, 8'h5a, 8'h44, 8'h4b, 9'h002, 4'h0};
      rows[17] = '{f1(OP_ROL, 1'b0, 8'h10, SEL_ACC, 8'h12), jt, 8'h5a, 8'h44, 8'h68, 9'h002, 4'h0};
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(ADDR_STATUS, q);
      chk(q, 32'h0000_0000);
      rd(ADDR_ACCIDX, q);
      chk(q, 32'h0000_0000);
      rd(8'h40, q);
      chk(q, RD_UNMAPPED);
      $display("reset test done");
      for (int r = 0; r < 18; r++) begin
         run_prog(rows[r].l1, rows[r].l3);
         rd(ADDR_STATUS, q);
         chk({19'h0, q[15:12], q[8:0]}, {19'h0, rows[r].dep, rows[r].pc});
         rd(ADDR_ACCIDX, q);
         chk({16'h0, q[15:0]}, {16'h0, rows[r].sx, rows[r].acc});
         wr(ADDR_RADDR, 32'h0000_0010);
         repeat (2) @(posedge clk);
         rd(ADDR_RDATA, q);
         chk({24'h0, q[7:0]}, {24'h0, rows[r].r10});
         $display("row %0d done", r);
      end
      wr(ADDR_CTRL, 32'h0000_0001);
      wr(ADDR_PADDR, 32'h0000_0002);
      wr(ADDR_PDATA, {3'h0, jt});
      wr(ADDR_CTRL, 32'h0000_0000);
      repeat (8) @(posedge clk);
      wr(ADDR_CTRL, 32'h0000_0002);
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (60) @(posedge clk);
      wr(ADDR_CTRL, 32'h0000_0000);
      repeat (8) @(posedge clk);
      rd(ADDR_STATUS, q);
      chk({19'h0, q[15:12], q[8:0]}, {19'h0, 4'h0, 9'h002});
      $display("refused load test done");
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (10) @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(ADDR_STATUS, q);
      chk(q, 32'h0000_0000);
      rd(ADDR_ACCIDX, q);
      chk(q, 32'h0000_0000);
      $display("mid-run reset test done");
      final_report();
   end
endmodule : test_sequencer_command_line_decoder
